// file: hdl/diag_cfg_pkg.sv
// Constants and types for the battery-short configuration block
package diag_cfg_pkg;
    localparam int frame_width = 32;
    localparam int rw_bit = 31;
    localparam int sel_msb = 30;
    localparam int sel_lsb = 24;
    localparam logic [6:0] sel_config_low = 7'h02;
    localparam logic [6:0] sel_config_high = 7'h03;
    localparam int channels = 8;
    localparam int channels_per_word = 4;
    localparam int field_stride = 6;
    localparam int thr_width = 2;
    localparam int retry_width = 4;
    // Threshold sits above retry inside each 6-bit slot; slot 0 is topmost
    localparam int thr_lsb_in_slot = 4;
    localparam int retry_lsb_in_slot = 0;
    localparam int top_slot_lsb = 18;
    localparam logic [1:0] thr_reset = 2'h3;
    localparam logic [3:0] retry_reset = 4'hf;
    localparam int retry_scale = 16;
    localparam int retry_count_width = 8;

    typedef struct packed {
        logic [1:0] threshold;
        logic [3:0] retry;
    } channel_cfg_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } frame_t;
endpackage

// file: hdl/diag_config_spi_regs.sv
// Battery-short configuration words reached by 32-bit serial frames
//
// What this block does
// - Bit 31 is read (0) or write (1) and selector 0x02 addresses channels zero to three.
// - Selector 0x03 addresses the word for channels four to seven.
// - Each channel has a 2-bit threshold at 23:22, 17:16, 11:10, 5:4 (0.7 to 1.3 V).
// - Every threshold resets to code 11, the highest.
// - Each channel has a 4-bit retry field at 21:18, 15:12, 9:6, 3:0.
// - After a battery short a channel retries after 16 times its retry field in PWM periods.
// - Every retry field resets to all ones, 240 PWM periods.
// - The upper word uses the same layout, channel four topmost, seven lowest.
// - The answer has bit 31 clear, the same selector and the stored settings.
`timescale 1ns/1ps
module diag_config_spi_regs
    import diag_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Received frame, one-cycle valid
    input wire frame_t rx_frame,
    // Answer frame, one-cycle valid
    output frame_t tx_frame,
    // Channel timing and faults
    input wire logic pwm_period,
    input wire logic [channels-1:0] battery_short_fault,
    // Settings to the comparators and retry results
    output logic [channels*thr_width-1:0] battery_short_threshold,
    output logic [channels-1:0] battery_short_retry,
    output logic [channels-1:0] battery_short_waiting
);
    channel_cfg_t cfg [channels];
    channel_cfg_t next_cfg [channels];
    logic [6:0] sel;
    logic is_low;
    logic is_high;
    logic is_write;
    logic write_low;
    logic write_high;
    logic [23:0] stored_low;
    logic [23:0] stored_high;
    logic [channels-1:0] retry_now;
    logic [channels-1:0] waiting;

    assign sel = rx_frame.data[sel_msb:sel_lsb];
    assign is_low = rx_frame.valid && sel == sel_config_low;
    assign is_high = rx_frame.valid && sel == sel_config_high;
    assign is_write = rx_frame.data[rw_bit];
    assign write_low = is_low && is_write;
    assign write_high = is_high && is_write;

    function automatic logic [23:0] pack_word(input int base);
        logic [23:0] w;
        w = '0;
        for (int i = 0; i < channels_per_word; i++) begin
            w[top_slot_lsb - i*field_stride +: field_stride] = cfg[base+i];
        end
        return w;
    endfunction

    always_comb begin
        stored_low = pack_word(0);
        stored_high = pack_word(channels_per_word);
    end

    always_comb begin
        for (int c = 0; c < channels; c++) begin
            next_cfg[c] = cfg[c];
        end
        for (int i = 0; i < channels_per_word; i++) begin
            if (write_low) begin
                next_cfg[i] = rx_frame.data[top_slot_lsb - i*field_stride +: field_stride];
            end
            if (write_high) begin
                next_cfg[channels_per_word + i] =
                    rx_frame.data[top_slot_lsb - i*field_stride +: field_stride];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < channels; c++) begin
                cfg[c] <= '{threshold: thr_reset, retry: retry_reset};
            end
        end else begin
            for (int c = 0; c < channels; c++) begin
                cfg[c] <= next_cfg[c];
            end
        end
    end

    // answer with settings before the write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_frame <= '0;
        end else begin
            tx_frame.valid <= is_low || is_high;
            tx_frame.data <= {1'b0, sel, is_high ? stored_high : stored_low};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            battery_short_threshold <= {channels{thr_reset}};
        end else begin
            for (int c = 0; c < channels; c++) begin
                battery_short_threshold[c*thr_width +: thr_width] <= cfg[c].threshold;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            battery_short_retry <= '0;
        end else begin
            battery_short_retry <= retry_now;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            battery_short_waiting <= '0;
        end else begin
            battery_short_waiting <= waiting;
        end
    end

    retry_timer u_timer_0 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[0]),
        .retry(cfg[0].retry),
        .retry_now(retry_now[0]),
        .waiting(waiting[0])
    );

    retry_timer u_timer_1 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[1]),
        .retry(cfg[1].retry),
        .retry_now(retry_now[1]),
        .waiting(waiting[1])
    );

    retry_timer u_timer_2 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[2]),
        .retry(cfg[2].retry),
        .retry_now(retry_now[2]),
        .waiting(waiting[2])
    );

    retry_timer u_timer_3 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[3]),
        .retry(cfg[3].retry),
        .retry_now(retry_now[3]),
        .waiting(waiting[3])
    );

    retry_timer u_timer_4 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[4]),
        .retry(cfg[4].retry),
        .retry_now(retry_now[4]),
        .waiting(waiting[4])
    );

    retry_timer u_timer_5 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[5]),
        .retry(cfg[5].retry),
        .retry_now(retry_now[5]),
        .waiting(waiting[5])
    );

    retry_timer u_timer_6 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[6]),
        .retry(cfg[6].retry),
        .retry_now(retry_now[6]),
        .waiting(waiting[6])
    );

    retry_timer u_timer_7 (
        .clk_sys(clk_sys),
        .rst(rst),
        .pwm_period(pwm_period),
        .fault(battery_short_fault[7]),
        .retry(cfg[7].retry),
        .retry_now(retry_now[7]),
        .waiting(waiting[7])
    );
endmodule

// file: hdl/retry_timer.sv
// Per-channel battery-short retry timer counted in PWM periods
`timescale 1ns/1ps
module retry_timer
    import diag_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Events
    input wire logic pwm_period,
    input wire logic fault,
    input wire logic [3:0] retry,
    // Result
    output logic retry_now,
    output logic waiting
);
    logic [retry_count_width-1:0] count;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= '0;
            waiting <= 1'b0;
            retry_now <= 1'b0;
        end else begin
            retry_now <= 1'b0;
            if (fault && !waiting) begin
                count <= retry_count_width'({retry, 4'h0});
                waiting <= 1'b1;
            end else if (waiting && pwm_period) begin
                if (count <= retry_count_width'(1)) begin
                    waiting <= 1'b0;
                    retry_now <= 1'b1;
                end else begin
                    count <= count - retry_count_width'(1);
                end
            end else if (waiting && count == '0) begin
                waiting <= 1'b0;
                retry_now <= 1'b1;
            end
        end
    end
endmodule

// file: tb/cfg_chk_asserts.sv
// Port assertions for the configuration block
`timescale 1ns/1ps
module cfg_chk
    import diag_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Frames and thresholds
    input wire frame_t rx_frame,
    input wire frame_t tx_frame,
    input wire logic [15:0] battery_short_threshold
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire [31:0] d = rx_frame.data;
    wire [31:0] q = tx_frame.data;
    wire [15:0] t = battery_short_threshold;
    wire [7:0] f = {d[5:4], d[11:10], d[17:16], d[23:22]};
    wire k = rx_frame.valid && d[30:25] == 6'h01;
    property p_ans; k |=> tx_frame.valid && q[31:24] == {1'b0, $past(d[30:24])}; endproperty
    a_ans: assert property (p_ans) else $error("bad answer");
    property p_none; !k |=> !tx_frame.valid; endproperty
    a_none: assert property (p_none) else $error("extra answer");
    property p_read; rx_frame.valid && !d[31] |=> ##1 $stable(t); endproperty
    a_read: assert property (p_read) else $error("read changed");
    property p_wlo; k && d[31] && !d[24] |=> ##1 t[7:0] == $past(f, 2); endproperty
    a_wlo: assert property (p_wlo) else $error("low write");
    property p_whi; k && d[31] && d[24] |=> ##1 t[15:8] == $past(f, 2); endproperty
    a_whi: assert property (p_whi) else $error("high write");
    property p_rst; $fell(rst) |-> t == 16'hffff; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_rlo; tx_frame.valid && !q[24] |-> {q[23:22], q[5:4]} == {t[1:0], t[7:6]};
    endproperty
    a_rlo: assert property (p_rlo) else $error("low reply");
    property p_clr; tx_frame.valid |-> !q[31]; endproperty
    a_clr: assert property (p_clr) else $error("reply bit set");
endmodule
bind diag_config_spi_regs cfg_chk u_chk (.clk_sys, .rst, .rx_frame, .tx_frame,
    .battery_short_threshold);

// file: tb/host_model.sv
// Host model sending request frames
`timescale 1ns/1ps
module host_model
    import diag_cfg_pkg::*;
(
    // Clock and frame
    input wire logic clk_sys,
    output frame_t rx_frame
);
    initial rx_frame = '0;
    task automatic send(input logic [31:0] f);
        @(posedge clk_sys) #1;
        rx_frame <= '{1'b1, f};
        @(posedge clk_sys) #1;
        rx_frame <= '{1'b0, ~f};
    endtask
endmodule

// file: tb/tb.sv
// Bench for the configuration block
`timescale 1ns/1ps
module tb;
    import diag_cfg_pkg::*;
    logic clk_sys = 0, rst = 1, pwm_period = 0;
    logic [7:0] battery_short_fault = 0, battery_short_retry, battery_short_waiting;
    logic [15:0] battery_short_threshold;
    frame_t rx_frame, tx_frame;
    int n_fail = 0, n_compared = 0, h = 0;
    host_model host (.clk_sys, .rx_frame);
    diag_config_spi_regs DUT (.clk_sys, .rst, .rx_frame, .tx_frame, .pwm_period,
        .battery_short_fault, .battery_short_threshold, .battery_short_retry,
        .battery_short_waiting);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [32:0] g, e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %0t %h %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic [31:0] f, input logic [32:0] e);
        host.send(f);
        chk({tx_frame.valid, tx_frame.data}, e);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #5000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 rst = 0;
        xfer(32'h8246a1b3, 33'h102ffffff);
        xfer(32'h02000000, 33'h10246a1b3);
        xfer(32'h83000fff, 33'h103ffffff);
        xfer(32'h03000000, 33'h103000fff);
        host.send(32'h84000000);
        chk(33'(tx_frame.valid), 0);
        chk(33'(battery_short_threshold), 33'h0f0c9);
        battery_short_fault[0] <= 1;
        for (int i = 1; i < 40 && h == 0; i++) begin
            @(posedge clk_sys) #1;
            pwm_period <= 1;
            @(posedge clk_sys) #1;
            pwm_period <= 0;
            repeat (3) @(posedge clk_sys) #1 if (battery_short_retry[0] === 1'b1) h = i;
        end
        chk(33'(h), 16);
        chk(33'(battery_short_waiting), 33'h1);
        conclude();
    end
endmodule
